// [include/lue_ctrl_map.svh]
// lookup engine register map: offsets, field positions, reset values
// assumes byte-wide management access with 16-bit byte addresses
`ifndef LUE_CTRL_MAP_SVH
`define LUE_CTRL_MAP_SVH

`define LUE_NUM_PORTS 7
`define LUE_PRIO_W 3

`define LUE_ADDR_CTRL2 16'h0312
`define LUE_ADDR_AGE 16'h0313
`define LUE_ADDR_STAT 16'h0314
`define LUE_ADDR_MASK 16'h0315

`define LUE_RSVD_BIT 7
`define LUE_TRAP_BIT 6
`define LUE_DYN_FILT_BIT 5
`define LUE_STA_FILT_BIT 4
`define LUE_SCOPE_LSB 2
`define LUE_PRIO_LSB 0

`define LUE_LF_BIT 2
`define LUE_AF_BIT 1
`define LUE_WF_BIT 0
`define LUE_IRQ_W 3

`define LUE_CTRL2_RST 8'h00
`define LUE_AGE_RST 8'h4B
`define LUE_STAT_RST 3'h0
`define LUE_MASK_RST 3'h7

`endif

// [include/lue_pkg.sv]
// types shared by the lookup engine control block and its bench
// field positions and reset values live in lue_ctrl_map.svh
`include "lue_ctrl_map.svh"

package lue_pkg;

    typedef enum logic [1:0] {
        LUE_SCOPE_NONE = 2'b00,
        LUE_SCOPE_DYN = 2'b01,
        LUE_SCOPE_STA = 2'b10,
        LUE_SCOPE_ALL = 2'b11
    } lue_scope_e;

    typedef enum logic [1:0] {
        LUE_PRIO_DA = 2'b00,
        LUE_PRIO_SA = 2'b01,
        LUE_PRIO_HIGH = 2'b10,
        LUE_PRIO_LOW = 2'b11
    } lue_prio_sel_e;

    typedef enum logic {
        LUE_FL_IDLE = 1'b0,
        LUE_FL_BUSY = 1'b1
    } lue_flush_st_e;

    typedef struct packed {
        logic hit;
        logic is_static;
        logic [`LUE_NUM_PORTS-1:0] entry_map;
        logic [`LUE_NUM_PORTS-1:0] vlan_map;
    } lue_lookup_s;

    typedef struct packed {
        logic reserved_mc;
        logic dtag_mode;
        logic [`LUE_PRIO_W-1:0] da_prio;
        logic [`LUE_PRIO_W-1:0] sa_prio;
    } lue_pkt_s;

    typedef struct packed {
        logic start;
        logic dyn;
        logic sta;
    } lue_flush_s;

endpackage : lue_pkg

// [hdl/lue_ctrl.sv]
// lookup engine control and bucket-event interrupt registers
// assumes byte-wide management port and same-clock datapath inputs
`timescale 1ns/1ps
`default_nettype none

module lue_ctrl
    import lue_pkg::*;
#(
    parameter int AGE_CNT_W = 3
) (
    input wire logic clk_sys, // 25 MHz switch clock
    input wire logic rst_n, // async reset, active low
    input wire logic [15:0] mgmt_addr, // byte address
    input wire logic mgmt_wr, // write strobe
    input wire logic mgmt_rd, // read strobe
    input wire logic [7:0] mgmt_wdata, // write data
    output logic [7:0] mgmt_rdata, // read data, next cycle
    output logic mgmt_rvalid, // read data valid pulse
    input wire lue_lookup_s lookup, // address lookup result
    input wire lue_pkt_s pkt, // packet attributes
    input wire logic [`LUE_NUM_PORTS-1:0] host_map, // host port
    output logic [`LUE_NUM_PORTS-1:0] fwd_map, // forward ports
    output logic [`LUE_PRIO_W-1:0] addr_based_priority, // prio
    input wire logic [AGE_CNT_W-1:0] age_count, // entry age count
    output logic [8+AGE_CNT_W-1:0] age_limit_sec, // aging time
    input wire logic flush_table_req, // table flush trigger
    input wire logic flush_done, // datapath finished flush
    output lue_flush_s flush_cmd, // flush start and scope
    output logic flush_busy, // trigger bit reads set
    input wire logic ev_learn_fail, // bucket all static
    input wire logic ev_almost_full, // static write, 2-3 valid
    input wire logic ev_write_fail, // static write, bucket full
    output logic lookup_engine_summary_irq, // OR of status
    output logic irq_req // unmasked status present
);

    function automatic logic hit_addr(input logic [15:0] a,
                                      input logic [15:0] ref_a);
        hit_addr = (a == ref_a);
    endfunction : hit_addr

    // egress filter: the vlan map can only narrow the lookup result,
    // it never adds a port to it
    function automatic logic [`LUE_NUM_PORTS-1:0] egress_filter(
        input logic [`LUE_NUM_PORTS-1:0] entry_map,
        input logic [`LUE_NUM_PORTS-1:0] vlan_map,
        input logic enable
    );
        egress_filter = entry_map;
        if (enable) begin
            egress_filter = entry_map & vlan_map;
        end
    endfunction : egress_filter

    // higher and lower compare the raw three-bit codes, so a larger
    // code counts as the higher priority
    function automatic logic [`LUE_PRIO_W-1:0] pick_prio(
        input lue_prio_sel_e sel,
        input logic [`LUE_PRIO_W-1:0] da,
        input logic [`LUE_PRIO_W-1:0] sa
    );
        pick_prio = da;
        unique case (sel)
            LUE_PRIO_DA: pick_prio = da;
            LUE_PRIO_SA: pick_prio = sa;
            LUE_PRIO_HIGH: pick_prio = (da > sa) ? da : sa;
            LUE_PRIO_LOW: pick_prio = (da < sa) ? da : sa;
        endcase
    endfunction : pick_prio

    // register file state
    logic [7:0] ctrl2_reg;
    logic [7:0] ctrl2_next;
    logic [7:0] age_reg;
    logic [7:0] age_next;
    logic [`LUE_IRQ_W-1:0] stat_reg;
    logic [`LUE_IRQ_W-1:0] stat_next;
    logic [`LUE_IRQ_W-1:0] mask_reg;
    logic [`LUE_IRQ_W-1:0] mask_next;
    logic [7:0] rdata_next;
    logic rvalid_next;
    logic [`LUE_IRQ_W-1:0] ev_vec;
    logic [`LUE_IRQ_W-1:0] w1c_vec;

    // flush sequencer
    lue_flush_st_e fl_state_reg;
    lue_flush_st_e fl_state_next;
    lue_flush_s flush_cmd_next;
    lue_scope_e scope;

    // datapath outputs
    logic [`LUE_NUM_PORTS-1:0] fwd_next;
    logic [`LUE_PRIO_W-1:0] prio_next;
    logic [8+AGE_CNT_W-1:0] age_lim_next;
    logic summary_next;
    logic irq_next;
    logic trap_hit;

    assign scope = lue_scope_e'(ctrl2_reg[`LUE_SCOPE_LSB +: 2]);

    // events are same-clock pulses; a held level keeps setting its bit
    always_comb begin
        ev_vec = '0;
        ev_vec[`LUE_LF_BIT] = ev_learn_fail;
        ev_vec[`LUE_AF_BIT] = ev_almost_full;
        ev_vec[`LUE_WF_BIT] = ev_write_fail;
    end

    // register writes and status bits
    always_comb begin
        ctrl2_next = ctrl2_reg;
        age_next = age_reg;
        mask_next = mask_reg;
        w1c_vec = '0;
        if (mgmt_wr) begin
            if (hit_addr(mgmt_addr, `LUE_ADDR_CTRL2)) begin
                ctrl2_next = mgmt_wdata;
            end
            if (hit_addr(mgmt_addr, `LUE_ADDR_AGE)) begin
                age_next = mgmt_wdata;
            end
            if (hit_addr(mgmt_addr, `LUE_ADDR_STAT)) begin
                w1c_vec = mgmt_wdata[`LUE_IRQ_W-1:0];
            end
            if (hit_addr(mgmt_addr, `LUE_ADDR_MASK)) begin
                mask_next = mgmt_wdata[`LUE_IRQ_W-1:0];
            end
        end
        // completion clears the scope; it beats a same-cycle write
        // so software never sees a stale scope after the flush
        if (fl_state_reg == LUE_FL_BUSY && flush_done) begin
            ctrl2_next[`LUE_SCOPE_LSB +: 2] = LUE_SCOPE_NONE;
        end
        // a new event wins over a clear in the same cycle
        stat_next = (stat_reg & ~w1c_vec) | ev_vec;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl2_reg <= `LUE_CTRL2_RST;
            age_reg <= `LUE_AGE_RST;
            stat_reg <= `LUE_STAT_RST;
            mask_reg <= `LUE_MASK_RST;
        end else begin
            ctrl2_reg <= ctrl2_next;
            age_reg <= age_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
        end
    end

    // register reads: unmapped addresses return zero; between reads
    // the last word is held so a slow master can still pick it up
    always_comb begin
        rdata_next = mgmt_rdata;
        rvalid_next = mgmt_rd;
        if (mgmt_rd) begin
            rdata_next = 8'h00;
            if (hit_addr(mgmt_addr, `LUE_ADDR_CTRL2)) begin
                rdata_next = ctrl2_reg;
            end
            if (hit_addr(mgmt_addr, `LUE_ADDR_AGE)) begin
                rdata_next = age_reg;
            end
            if (hit_addr(mgmt_addr, `LUE_ADDR_STAT)) begin
                rdata_next[`LUE_IRQ_W-1:0] = stat_reg;
            end
            if (hit_addr(mgmt_addr, `LUE_ADDR_MASK)) begin
                rdata_next[`LUE_IRQ_W-1:0] = mask_reg;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mgmt_rdata <= 8'h00;
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rdata <= rdata_next;
            mgmt_rvalid <= rvalid_next;
        end
    end

    // flush sequencer: the trigger is held busy until the datapath
    // reports done, then drops, which is how the trigger self-clears
    always_comb begin
        fl_state_next = fl_state_reg;
        flush_cmd_next = '0;
        unique case (fl_state_reg)
            LUE_FL_IDLE: begin
                if (flush_table_req && scope != LUE_SCOPE_NONE) begin
                    flush_cmd_next.start = 1'b1;
                    flush_cmd_next.dyn = scope[0];
                    flush_cmd_next.sta = scope[1];
                    fl_state_next = LUE_FL_BUSY;
                end
            end
            LUE_FL_BUSY: begin
                if (flush_done) begin
                    fl_state_next = LUE_FL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fl_state_reg <= LUE_FL_IDLE;
            flush_cmd <= '0;
        end else begin
            fl_state_reg <= fl_state_next;
            flush_cmd <= flush_cmd_next;
        end
    end

    assign flush_busy = (fl_state_reg == LUE_FL_BUSY);

    // the trap overrides any lookup result, hit or miss
    assign trap_hit = pkt.reserved_mc && pkt.dtag_mode &&
        ctrl2_reg[`LUE_TRAP_BIT];

    // forwarding and priority results for the packet now in lookup
    always_comb begin
        fwd_next = '0;
        if (trap_hit) begin
            fwd_next = host_map;
        end else if (lookup.hit && lookup.is_static) begin
            fwd_next = egress_filter(lookup.entry_map, lookup.vlan_map,
                ctrl2_reg[`LUE_STA_FILT_BIT]);
        end else if (lookup.hit) begin
            fwd_next = egress_filter(lookup.entry_map, lookup.vlan_map,
                ctrl2_reg[`LUE_DYN_FILT_BIT]);
        end
        prio_next = pick_prio(
            lue_prio_sel_e'(ctrl2_reg[`LUE_PRIO_LSB +: 2]),
            pkt.da_prio, pkt.sa_prio);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fwd_map <= '0;
            addr_based_priority <= '0;
        end else begin
            fwd_map <= fwd_next;
            addr_based_priority <= prio_next;
        end
    end

    // aging limit in seconds; the aging timer outside compares against
    // it. both operands are widened first so the largest period times
    // the largest count cannot wrap
    always_comb begin
        age_lim_next = (8+AGE_CNT_W)'(age_reg) *
            (8+AGE_CNT_W)'(age_count);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            age_limit_sec <= '0;
        end else begin
            age_limit_sec <= age_lim_next;
        end
    end

    // interrupt outputs follow the next status, so they rise at the
    // same edge that captures the event rather than one cycle later
    always_comb begin
        summary_next = |stat_next;
        irq_next = |(stat_next & ~mask_next);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lookup_engine_summary_irq <= 1'b0;
            irq_req <= 1'b0;
        end else begin
            lookup_engine_summary_irq <= summary_next;
            irq_req <= irq_next;
        end
    end

endmodule : lue_ctrl

`default_nettype wire

// [bench/lue_ctrl_assertions.sv]
// port checker for the lookup engine control block
// assumes one clock domain; bound to every lue_ctrl instance
`timescale 1ns/1ps
`default_nettype none

module lue_ctrl_assertions
    import lue_pkg::*;
(
    input wire logic clk_sys, // switch clock
    input wire logic rst_n, // async reset
    input wire lue_lookup_s lookup, // lookup result
    input wire lue_pkt_s pkt, // packet attributes
    input wire logic [6:0] fwd_map, // forward ports
    input wire logic [2:0] addr_based_priority, // priority
    input wire logic flush_done, // flush finished
    input wire lue_flush_s flush_cmd, // flush command
    input wire logic flush_busy, // flush running
    input wire logic ev_learn_fail, // learn fail event
    input wire logic ev_almost_full, // almost full event
    input wire logic ev_write_fail, // write fail event
    input wire logic lookup_engine_summary_irq, // summary
    input wire logic irq_req // unmasked request
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_trap_off;
        !(pkt.reserved_mc && pkt.dtag_mode);
    endsequence
    sequence s_go;
        flush_cmd.start ##1 !flush_cmd.start;
    endsequence

    property p_nohit;
        s_trap_off and !lookup.hit |=> fwd_map == 7'h00;
    endproperty
    property p_hit_sub;
        s_trap_off and lookup.hit |=>
            (fwd_map & ~$past(lookup.entry_map)) == 7'h00;
    endproperty
    property p_prio;
        1'b1 |=> addr_based_priority == $past(pkt.da_prio) ||
            addr_based_priority == $past(pkt.sa_prio);
    endproperty
    property p_evt;
        ev_learn_fail || ev_almost_full || ev_write_fail
            |=> lookup_engine_summary_irq;
    endproperty
    property p_gate;
        irq_req |-> lookup_engine_summary_irq;
    endproperty
    property p_fl_go;
        flush_cmd.start |-> s_go;
    endproperty
    property p_fl_scope;
        flush_cmd.start |-> flush_busy && (flush_cmd.dyn || flush_cmd.sta);
    endproperty
    property p_fl_end;
        flush_busy && flush_done |=> !flush_busy;
    endproperty

    a_nohit: assert property (p_nohit)
        else $error("forward map not empty on a miss");
    a_hit_sub: assert property (p_hit_sub)
        else $error("forward map outside entry map");
    a_prio: assert property (p_prio)
        else $error("priority from neither lookup");
    a_evt: assert property (p_evt)
        else $error("summary missing after event");
    a_gate: assert property (p_gate)
        else $error("request without status");
    a_fl_go: assert property (p_fl_go)
        else $error("flush start longer than a pulse");
    a_fl_scope: assert property (p_fl_scope)
        else $error("flush start without scope or busy");
    a_fl_end: assert property (p_fl_end)
        else $error("busy after flush done");
endmodule : lue_ctrl_assertions

bind lue_ctrl lue_ctrl_assertions u_chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .lookup(lookup), .pkt(pkt), .fwd_map(fwd_map),
    .addr_based_priority(addr_based_priority), .flush_done(flush_done),
    .flush_cmd(flush_cmd), .flush_busy(flush_busy),
    .ev_learn_fail(ev_learn_fail), .ev_almost_full(ev_almost_full),
    .ev_write_fail(ev_write_fail),
    .lookup_engine_summary_irq(lookup_engine_summary_irq),
    .irq_req(irq_req));

`default_nettype wire

// [bench/lue_ctrl_test.sv]
// self-checking bench for the lookup engine control block
// drives every port itself at the falling clock edge
`timescale 1ns/1ps
`default_nettype none

module lue_ctrl_test
    import lue_pkg::*;
;
    logic clk_sys = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic req = 1'b0, done = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [7:0] wd = 8'h00, c, a, rdata;
    logic [2:0] ev = 3'h0, cnt = 3'h0, prio;
    logic [6:0] host = 7'h00, fwd;
    logic [10:0] agel;
    logic [31:0] seed = 32'h0000001B, r;
    logic rvalid, sum, irq, busy;
    lue_lookup_s lk = '0;
    lue_pkt_s pk = '0;
    lue_flush_s fc;
    int failures = 0, comparisons = 0;
    logic [15:0] radr[5] = '{16'h0312, 16'h0313, 16'h0314, 16'h0315, 16'h0316};
    logic [7:0] rrst[5] = '{8'h00, 8'h4B, 8'h00, 8'h07, 8'h00};

    lue_ctrl u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .mgmt_addr(adr),
        .mgmt_wr(wr), .mgmt_rd(rd), .mgmt_wdata(wd), .mgmt_rdata(rdata),
        .mgmt_rvalid(rvalid), .lookup(lk), .pkt(pk), .host_map(host),
        .fwd_map(fwd), .addr_based_priority(prio), .age_count(cnt),
        .age_limit_sec(agel), .flush_table_req(req), .flush_done(done),
        .flush_cmd(fc), .flush_busy(busy), .ev_learn_fail(ev[2]),
        .ev_almost_full(ev[1]), .ev_write_fail(ev[0]),
        .lookup_engine_summary_irq(sum), .irq_req(irq));

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [6:0] efwd(logic [7:0] k, lue_lookup_s l,
        lue_pkt_s p, logic [6:0] h);
        if (p.reserved_mc && p.dtag_mode && k[6]) return h;
        if (!l.hit) return 7'h00;
        if (l.is_static ? k[4] : k[5]) return l.entry_map & l.vlan_map;
        return l.entry_map;
    endfunction : efwd

    function automatic logic [2:0] eprio(logic [1:0] s, lue_pkt_s p);
        case (s)
            2'h0: return p.da_prio;
            2'h1: return p.sa_prio;
            2'h2: return (p.da_prio > p.sa_prio) ? p.da_prio : p.sa_prio;
            default: return (p.da_prio < p.sa_prio) ? p.da_prio : p.sa_prio;
        endcase
    endfunction : eprio

    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task wrt(input logic [15:0] ad, input logic [7:0] d);
        @(negedge clk_sys);
        wr = 1'b1;
        adr = ad;
        wd = d;
        @(negedge clk_sys);
        wr = 1'b0;
    endtask : wrt

    task rdc(input logic [15:0] ad, input logic [7:0] e);
        @(negedge clk_sys);
        rd = 1'b1;
        adr = ad;
        @(negedge clk_sys);
        rd = 1'b0;
        chk("rvalid", 16'(rvalid), 16'h0001);
        chk("rdata", 16'(rdata), 16'(e));
    endtask : rdc

    task end_sim();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    initial begin
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        foreach (radr[i]) rdc(radr[i], rrst[i]);
        for (int i = 0; i < 40; i++) begin
            // scope kept at 00 so no flush starts here
            r = rnd();
            c = (i == 0) ? 8'hF3 : r[7:0] & 8'hF3;
            a = r[15:8];
            wrt(16'h0312, c);
            wrt(16'h0313, a);
            rdc(16'h0312, c);
            r = rnd();
            lk = r[15:0];
            pk = r[23:16];
            host = r[30:24];
            cnt = 3'(rnd());
            @(negedge clk_sys);
            chk("fwd", 16'(fwd), 16'(efwd(c, lk, pk, host)));
            chk("prio", 16'(prio), 16'(eprio(c[1:0], pk)));
            chk("age", 16'(agel), 16'(a) * 16'(cnt));
        end
        for (int i = 0; i < 3; i++) begin
            @(negedge clk_sys);
            ev[i] = 1'b1;
            @(negedge clk_sys);
            ev = 3'h0;
            chk("summary", 16'(sum), 16'h0001);
            chk("irq masked", 16'(irq), 16'h0000);
            rdc(16'h0314, 8'(1 << i));
            wrt(16'h0315, 8'(~(1 << i) & 7));
            @(negedge clk_sys);
            chk("irq", 16'(irq), 16'h0001);
            wrt(16'h0314, 8'(1 << i));
            @(negedge clk_sys);
            chk("cleared", 16'({sum, irq}), 16'h0000);
            wrt(16'h0315, 8'h07);
        end
        for (int s = 0; s < 4; s++) begin
            wrt(16'h0312, 8'(s << 2));
            @(negedge clk_sys);
            req = 1'b1;
            @(negedge clk_sys);
            req = 1'b0;
            chk("flush", 16'({fc, busy}), (s == 0) ? 16'h0000 :
                16'({1'b1, s[0], s[1], 1'b1}));
            done = 1'b1;
            @(negedge clk_sys);
            done = 1'b0;
            chk("busy", 16'(busy), 16'h0000);
            rdc(16'h0312, 8'h00);
        end
        // event and clear in one cycle: the event must win
        @(negedge clk_sys);
        ev = 3'h1;
        wr = 1'b1;
        adr = 16'h0314;
        wd = 8'h01;
        @(negedge clk_sys);
        ev = 3'h0;
        wr = 1'b0;
        rdc(16'h0314, 8'h01);
        wrt(16'h0314, 8'h01);
        rdc(16'h0314, 8'h00);
        // reserved mask bits stay zero
        wrt(16'h0315, 8'hFF);
        rdc(16'h0315, 8'h07);
        // a trigger while busy is ignored; completion beats a write
        wrt(16'h0312, 8'h0C);
        @(negedge clk_sys);
        req = 1'b1;
        @(negedge clk_sys);
        req = 1'b0;
        @(negedge clk_sys);
        req = 1'b1;
        @(negedge clk_sys);
        req = 1'b0;
        chk("busy req", 16'({fc, busy}), 16'h0001);
        done = 1'b1;
        wr = 1'b1;
        adr = 16'h0312;
        wd = 8'h2D;
        @(negedge clk_sys);
        done = 1'b0;
        wr = 1'b0;
        chk("busy done", 16'(busy), 16'h0000);
        rdc(16'h0312, 8'h21);
        // reset in mid-run restores every register
        wrt(16'h0313, 8'h11);
        @(negedge clk_sys);
        rst_n = 1'b0;
        @(negedge clk_sys);
        rst_n = 1'b1;
        foreach (radr[i]) rdc(radr[i], rrst[i]);
        end_sim();
    end
endmodule : lue_ctrl_test

`default_nettype wire
